// ==== src/ddb_regs.svh ====
// Purpose: shared constants of the burst-of-two common-I/O memory link
// Assumes: 40 MHz system clock on both ends
// Notes: times are in ns; cycle counts are derived from them
`ifndef DDB_REGS_SVH
`define DDB_REGS_SVH
`define DDB_LANE_W 9
`define DDB_LANES 4
`define DDB_ADDR_W 8
`define DDB_BURST_LEN 2
`define DDB_SYS_PERIOD_NS 25
`define DDB_K_PERIOD_NS 200
`define DDB_K_HALF (`DDB_K_PERIOD_NS / `DDB_SYS_PERIOD_NS / 2)
`define DDB_LOCK_KCYCLES 16
`endif

// ==== src/ddb_pkg.sv ====
// Purpose: types shared by both ends of the memory link
// Assumes: nothing
// Notes: constants live in ddb_regs.svh
`default_nettype none
package ddb_pkg;
  typedef enum logic [1:0] {
    DDB_H_IDLE,
    DDB_H_WCMD,
    DDB_H_WDATA,
    DDB_H_RWAIT
  } ddb_host_state_type;
  typedef enum logic {
    DDB_LAT_ONE,
    DDB_LAT_TWO
  } ddb_lat_type;
endpackage
`default_nettype wire

// ==== src/ddb_link_if.sv ====
// Purpose: pins between the memory controller and the memory
// Assumes: both ends enable their data drivers active high
// Notes: an undriven data bus reads as zero
`include "ddb_regs.svh"
`default_nettype none
interface ddb_link_if #(
  parameter int LANES = `DDB_LANES,
  parameter int AW = `DDB_ADDR_W
);
  localparam int DW = LANES * `DDB_LANE_W;
  logic k;
  logic k_n;
  logic load_select_n;
  logic read_not_write;
  logic [AW-1:0] sync_address;
  logic [LANES-1:0] byte_write_strobe_n;
  logic [DW-1:0] host_dq;
  logic host_dq_oe;
  logic [DW-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DW-1:0] dq;
  logic echo_clock_true;
  logic echo_clock_comp;
  logic read_valid_flag;
  // controller wins a clash, so a turnaround fault corrupts its own read data
  assign dq = host_dq_oe ? host_dq : (dev_dq_oe ? dev_dq : '0);
  modport ctrl (
    output k, k_n, load_select_n, read_not_write, sync_address,
    output byte_write_strobe_n, host_dq, host_dq_oe,
    input dq, echo_clock_true, echo_clock_comp, read_valid_flag
  );
  modport mem (
    input k, k_n, load_select_n, read_not_write, sync_address,
    input byte_write_strobe_n, dq,
    output dev_dq, dev_dq_oe, echo_clock_true, echo_clock_comp, read_valid_flag
  );
endinterface
`default_nettype wire

// ==== src/ddb_pair_buf.sv ====
// Purpose: small shifting buffer with valid and ready on both sides
// Assumes: DEPTH of at least two
// Notes: head entry and its valid come straight from flip-flops
`default_nettype none
module ddb_pair_buf #(
  parameter int W = 36,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] ent [DEPTH];
  logic [W-1:0] next_ent [DEPTH];
  logic [DEPTH-1:0] full;
  logic [DEPTH-1:0] next_full;
  logic [DEPTH-1:0] sh_full;
  logic [DEPTH-1:0] ins;
  logic pop;
  logic push;

  assign pop = full[0] & out_ready;
  assign in_ready = ~full[DEPTH-1];
  assign push = in_valid & in_ready;
  assign out_valid = full[0];
  assign out_data = ent[0];
  assign sh_full = pop ? (full >> 1) : full;
  // a word goes into the first free slot after the shift
  assign ins = {DEPTH{push}} & ~sh_full & {sh_full[DEPTH-2:0], 1'b1};
  assign next_full = sh_full | ins;

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    if (i == DEPTH - 1) begin : g_last
      assign next_ent[i] = ins[i] ? in_data : ent[i];
    end else begin : g_mid
      assign next_ent[i] = ins[i] ? in_data : (pop ? ent[i+1] : ent[i]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        ent[i] <= '0;
      end
    end else begin
      full <= next_full;
      ent <= next_ent;
    end
  end
endmodule
`default_nettype wire

// ==== src/ddb_sram_end.sv ====
// Purpose: memory end of the burst-of-two common-I/O link
// Assumes: link pins arrive asynchronously; SYS_CLK much faster than K
// Notes: array is an inferred register file sized by AW
//
// Overview of operation
// - every access moves exactly two words
// - commands sampled on true clock rising only
// - read and write addresses both on true clock rise
// - controller sends write words one cycle later
// - byte strobes sampled with each write word
// - first read word one cycle after command, two with loop locked
// - second read word on second complement rise, third with loop locked
// - buffered late write completes at the next write command
// - shared data bus, controller releases for reads
// - echo clocks aligned with read data
// - loop disabled gives one cycle latency
// - valid flag marks returned read data
// - echo clocks toggle continuously
// - deselected edges ignore the address
`include "ddb_regs.svh"
`default_nettype none
module ddb_sram_end #(
  parameter int LANES = `DDB_LANES,
  parameter int AW = `DDB_ADDR_W,
  parameter int LOCK_K = `DDB_LOCK_KCYCLES
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // link toward the controller
  ddb_link_if.mem LINK,
  // loop strap and latency status
  input wire logic LOOP_DISABLE_N,
  output logic LATENCY_ONE
);
  localparam int LW = `DDB_LANE_W;
  localparam int DW = LANES * LW;
  localparam int SW = 5 + AW + LANES + DW;
  localparam int CW = $clog2(LOCK_K + 1);

  // input capture
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic k_prev;
  logic kn_prev;
  logic s_k;
  logic s_kn;
  logic s_load_n;
  logic s_rnw;
  logic s_loop_n;
  logic [AW-1:0] s_addr;
  logic [LANES-1:0] s_bw_n;
  logic [DW-1:0] s_dq;

  // decoded edges and commands
  logic k_rise;
  logic kn_rise;
  logic sel;
  logic rd_cmd;
  logic wr_cmd;

  // state and next values
  logic [1:0] rd_v;
  logic [1:0] next_rd_v;
  logic [AW-1:0] rd_a0;
  logic [AW-1:0] next_rd_a0;
  logic [AW-1:0] rd_a1;
  logic [AW-1:0] next_rd_a1;
  logic [AW-1:0] out_addr;
  logic [AW-1:0] next_out_addr;
  logic [DW-1:0] dq_out;
  logic [DW-1:0] next_dq_out;
  logic dq_oe;
  logic next_dq_oe;
  logic vld;
  logic next_vld;
  logic echo_t;
  logic next_echo_t;
  logic echo_c;
  logic next_echo_c;
  logic [AW-1:0] wb_addr;
  logic [AW-1:0] next_wb_addr;
  logic [2*DW-1:0] wb_data;
  logic [2*DW-1:0] next_wb_data;
  logic [2*LANES-1:0] wb_be;
  logic [2*LANES-1:0] next_wb_be;
  logic wcap0;
  logic next_wcap0;
  logic wcap1;
  logic next_wcap1;
  logic [CW-1:0] lock_cnt;
  logic [CW-1:0] next_lock_cnt;
  ddb_pkg::ddb_lat_type mode;
  ddb_pkg::ddb_lat_type next_mode;

  // array and fetch path
  logic [2*DW-1:0] mem [2**AW];
  logic src_v;
  logic [AW-1:0] src_a;
  logic [AW-1:0] fetch_a;
  logic fetch_w;
  logic [2*DW-1:0] arr_pair;
  logic [DW-1:0] arr_word;
  logic [DW-1:0] buf_word;
  logic [LANES-1:0] buf_en;
  logic [DW-1:0] merged;

  assign sync_in = {LINK.k, LINK.k_n, LINK.load_select_n, LINK.read_not_write,
                    LOOP_DISABLE_N, LINK.sync_address, LINK.byte_write_strobe_n, LINK.dq};
  assign {s_k, s_kn, s_load_n, s_rnw, s_loop_n, s_addr, s_bw_n, s_dq} = sync2;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1 <= '0;
      sync2 <= '0;
      k_prev <= 1'b0;
      kn_prev <= 1'b0;
    end else begin
      sync1 <= sync_in;
      sync2 <= sync1;
      k_prev <= s_k;
      kn_prev <= s_kn;
    end
  end

  // all pins share one sync delay, so values line up with the clock edges
  assign k_rise = s_k & ~k_prev;
  assign kn_rise = s_kn & ~kn_prev;
  assign sel = k_rise & ~s_load_n;
  assign rd_cmd = sel & s_rnw;
  assign wr_cmd = sel & ~s_rnw;

  // bypassed loop takes the read from one rise back, locked loop from two
  assign src_v = (mode == ddb_pkg::DDB_LAT_ONE) ? rd_v[0] : rd_v[1];
  assign src_a = (mode == ddb_pkg::DDB_LAT_ONE) ? rd_a0 : rd_a1;

  // true and complement rises never coincide, so one fetch port serves both
  assign fetch_a = k_rise ? src_a : out_addr;
  assign fetch_w = ~k_rise;
  assign arr_pair = mem[fetch_a];
  assign arr_word = fetch_w ? arr_pair[2*DW-1:DW] : arr_pair[DW-1:0];
  assign buf_word = fetch_w ? wb_data[2*DW-1:DW] : wb_data[DW-1:0];
  assign buf_en = (wb_addr != fetch_a) ? '0 :
                  (fetch_w ? wb_be[2*LANES-1:LANES] : wb_be[LANES-1:0]);

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign merged[l*LW +: LW] = buf_en[l] ? buf_word[l*LW +: LW]
                                          : arr_word[l*LW +: LW];
  end

  // late write: the buffer drains into the array at the next write command
  always_ff @(posedge SYS_CLK) begin
    if (wr_cmd) begin
      for (int i = 0; i < 2 * LANES; i++) begin
        if (wb_be[i]) begin
          mem[wb_addr][i*LW +: LW] <= wb_data[i*LW +: LW];
        end
      end
    end
  end

  always_comb begin
    next_rd_v = rd_v;
    next_rd_a0 = rd_a0;
    next_rd_a1 = rd_a1;
    next_out_addr = out_addr;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_vld = vld;
    next_wb_addr = wb_addr;
    next_wb_data = wb_data;
    next_wb_be = wb_be;
    next_wcap0 = wcap0;
    next_wcap1 = wcap1;
    next_lock_cnt = lock_cnt;
    next_mode = mode;
    // echoes follow the input clocks even while the bus is released
    next_echo_t = s_k;
    next_echo_c = s_kn;
    if (k_rise) begin
      next_rd_v = {rd_v[0], rd_cmd};
      next_rd_a0 = s_addr;
      next_rd_a1 = rd_a0;
      next_dq_oe = src_v;
      next_vld = src_v;
      next_out_addr = src_a;
      if (src_v) begin
        next_dq_out = merged;
      end
      if (!s_loop_n) begin
        next_lock_cnt = '0;
        next_mode = ddb_pkg::DDB_LAT_ONE;
      end else if (lock_cnt == CW'(LOCK_K)) begin
        next_mode = ddb_pkg::DDB_LAT_TWO;
      end else begin
        next_lock_cnt = lock_cnt + 1'b1;
      end
      if (wcap0) begin
        next_wb_data[DW-1:0] = s_dq;
        next_wb_be[LANES-1:0] = ~s_bw_n;
        next_wcap1 = 1'b1;
      end
      next_wcap0 = wr_cmd;
      if (wr_cmd) begin
        next_wb_addr = s_addr;
        next_wb_be = '0;
      end
    end
    if (kn_rise) begin
      if (dq_oe) begin
        next_dq_out = merged;
      end
      if (wcap1) begin
        next_wb_data[2*DW-1:DW] = s_dq;
        next_wb_be[2*LANES-1:LANES] = ~s_bw_n;
        next_wcap1 = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_v <= '0;
      rd_a0 <= '0;
      rd_a1 <= '0;
      out_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      vld <= 1'b0;
      echo_t <= 1'b0;
      echo_c <= 1'b0;
      wb_addr <= '0;
      wb_data <= '0;
      wb_be <= '0;
      wcap0 <= 1'b0;
      wcap1 <= 1'b0;
      lock_cnt <= '0;
      mode <= ddb_pkg::DDB_LAT_ONE;
      LATENCY_ONE <= 1'b1;
    end else begin
      rd_v <= next_rd_v;
      rd_a0 <= next_rd_a0;
      rd_a1 <= next_rd_a1;
      out_addr <= next_out_addr;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      vld <= next_vld;
      echo_t <= next_echo_t;
      echo_c <= next_echo_c;
      wb_addr <= next_wb_addr;
      wb_data <= next_wb_data;
      wb_be <= next_wb_be;
      wcap0 <= next_wcap0;
      wcap1 <= next_wcap1;
      lock_cnt <= next_lock_cnt;
      mode <= next_mode;
      LATENCY_ONE <= (next_mode == ddb_pkg::DDB_LAT_ONE);
    end
  end

  assign LINK.dev_dq = dq_out;
  assign LINK.dev_dq_oe = dq_oe;
  assign LINK.echo_clock_true = echo_t;
  assign LINK.echo_clock_comp = echo_c;
  assign LINK.read_valid_flag = vld;
endmodule
`default_nettype wire

// ==== src/ddb_ctrl_end.sv ====
// Purpose: controller end of the burst-of-two common-I/O link
// Assumes: K_HALF of at least two system cycles
// Notes: one access at a time; read words return through a small buffer
`include "ddb_regs.svh"
`default_nettype none
module ddb_ctrl_end #(
  parameter int LANES = `DDB_LANES,
  parameter int AW = `DDB_ADDR_W,
  parameter int K_HALF = `DDB_K_HALF,
  parameter int DEPTH = `DDB_BURST_LEN
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // link toward the memory
  ddb_link_if.ctrl LINK,
  // access requests
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [AW-1:0] REQ_ADDR,
  input wire logic [2*LANES*`DDB_LANE_W-1:0] REQ_WDATA,
  input wire logic [2*LANES-1:0] REQ_BE,
  output logic REQ_TAKEN,
  // read words
  output logic RD_VALID,
  output logic [LANES*`DDB_LANE_W-1:0] RD_DATA,
  input wire logic RD_READY
);
  localparam int DW = LANES * `DDB_LANE_W;
  localparam int PER = 2 * K_HALF;
  localparam int PW = $clog2(PER);
  localparam int RW = 3 + DW;
  // commands change mid-low, second write word mid-high, away from K edges
  localparam logic [PW-1:0] PH_CMD = PW'(PER - K_HALF / 2);
  localparam logic [PW-1:0] PH_W1 = PW'(K_HALF / 2);

  logic [PW-1:0] ph;
  logic [PW-1:0] next_ph;
  logic k;
  logic next_k;
  ddb_pkg::ddb_host_state_type state;
  ddb_pkg::ddb_host_state_type next_state;
  logic [AW-1:0] addr;
  logic [AW-1:0] next_addr;
  logic load_n;
  logic next_load_n;
  logic rnw;
  logic next_rnw;
  logic [LANES-1:0] bw_n;
  logic [LANES-1:0] next_bw_n;
  logic [DW-1:0] dq;
  logic [DW-1:0] next_dq;
  logic oe;
  logic next_oe;
  logic [2*DW-1:0] wd;
  logic [2*DW-1:0] next_wd;
  logic [2*LANES-1:0] wbe;
  logic [2*LANES-1:0] next_wbe;
  logic next_taken;

  // read return capture
  logic [RW-1:0] sync1;
  logic [RW-1:0] sync2;
  logic et_prev;
  logic ec_prev;
  logic s_et;
  logic s_ec;
  logic s_vld;
  logic [DW-1:0] s_dq;
  logic rx_valid;
  logic rx_last;
  logic rx_ready;
  logic buf_valid;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1 <= '0;
      sync2 <= '0;
      et_prev <= 1'b0;
      ec_prev <= 1'b0;
    end else begin
      sync1 <= {LINK.echo_clock_true, LINK.echo_clock_comp, LINK.read_valid_flag, LINK.dq};
      sync2 <= sync1;
      et_prev <= s_et;
      ec_prev <= s_ec;
    end
  end

  assign {s_et, s_ec, s_vld, s_dq} = sync2;
  // words are taken on echo edges while the memory flags them valid
  assign rx_valid = (state == ddb_pkg::DDB_H_RWAIT) & s_vld &
                    ((s_et & ~et_prev) | (s_ec & ~ec_prev));
  assign rx_last = rx_valid & s_ec & ~ec_prev;

  ddb_pair_buf #(
    .W(DW),
    .DEPTH(DEPTH)
  ) u_rx_buf (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .in_valid(rx_valid),
    .in_data(s_dq),
    .in_ready(rx_ready),
    .out_valid(buf_valid),
    .out_data(RD_DATA),
    .out_ready(RD_READY)
  );
  assign RD_VALID = buf_valid;

  always_comb begin
    next_ph = (ph == PW'(PER - 1)) ? '0 : ph + 1'b1;
    next_k = (next_ph < PW'(K_HALF));
    next_state = state;
    next_addr = addr;
    next_load_n = load_n;
    next_rnw = rnw;
    next_bw_n = bw_n;
    next_dq = dq;
    next_oe = oe;
    next_wd = wd;
    next_wbe = wbe;
    next_taken = 1'b0;
    if (next_ph == PH_CMD) begin
      next_load_n = 1'b1;
      next_oe = 1'b0;
      next_bw_n = '1;
      unique case (state)
        ddb_pkg::DDB_H_IDLE, ddb_pkg::DDB_H_WDATA: begin
          next_state = ddb_pkg::DDB_H_IDLE;
          // a read waits for an empty buffer so both words have room
          if (REQ_VALID && (REQ_WRITE || (rx_ready && !buf_valid))) begin
            next_load_n = 1'b0;
            next_rnw = ~REQ_WRITE;
            next_addr = REQ_ADDR;
            next_wd = REQ_WDATA;
            next_wbe = REQ_BE;
            next_taken = 1'b1;
            next_state = REQ_WRITE ? ddb_pkg::DDB_H_WCMD : ddb_pkg::DDB_H_RWAIT;
          end
        end
        ddb_pkg::DDB_H_WCMD: begin
          next_oe = 1'b1;
          next_dq = wd[DW-1:0];
          next_bw_n = ~wbe[LANES-1:0];
          next_state = ddb_pkg::DDB_H_WDATA;
        end
        ddb_pkg::DDB_H_RWAIT: begin
        end
      endcase
    end else if (next_ph == PH_W1 && state == ddb_pkg::DDB_H_WDATA) begin
      next_dq = wd[2*DW-1:DW];
      next_bw_n = ~wbe[2*LANES-1:LANES];
    end
    if (rx_last) begin
      next_state = ddb_pkg::DDB_H_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ph <= '0;
      k <= 1'b0;
      state <= ddb_pkg::DDB_H_IDLE;
      addr <= '0;
      load_n <= 1'b1;
      rnw <= 1'b1;
      bw_n <= '1;
      dq <= '0;
      oe <= 1'b0;
      wd <= '0;
      wbe <= '0;
      REQ_TAKEN <= 1'b0;
    end else begin
      ph <= next_ph;
      k <= next_k;
      state <= next_state;
      addr <= next_addr;
      load_n <= next_load_n;
      rnw <= next_rnw;
      bw_n <= next_bw_n;
      dq <= next_dq;
      oe <= next_oe;
      wd <= next_wd;
      wbe <= next_wbe;
      REQ_TAKEN <= next_taken;
    end
  end

  assign LINK.k = k;
  assign LINK.k_n = ~k;
  assign LINK.sync_address = addr;
  assign LINK.load_select_n = load_n;
  assign LINK.read_not_write = rnw;
  assign LINK.byte_write_strobe_n = bw_n;
  assign LINK.host_dq = dq;
  assign LINK.host_dq_oe = oe;
endmodule
`default_nettype wire

// ==== verif/ddb_link_sva.sv ====
// Purpose: timing checks on the pins between controller and memory
// Assumes: single SYS_CLK domain, K made by the controller divider
// Notes: echo idle bound has slack for the first K cycle after reset
`include "ddb_regs.svh"
`default_nettype none
module ddb_link_sva #(
  parameter int LANES = `DDB_LANES,
  parameter int AW = `DDB_ADDR_W,
  parameter int K_HALF = `DDB_K_HALF
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // command pins
  input wire logic k,
  input wire logic load_select_n,
  input wire logic read_not_write,
  input wire logic [AW-1:0] sync_address,
  input wire logic [LANES-1:0] byte_write_strobe_n,
  // data and echo pins
  input wire logic [LANES*`DDB_LANE_W-1:0] host_dq,
  input wire logic host_dq_oe,
  input wire logic [LANES*`DDB_LANE_W-1:0] dev_dq,
  input wire logic dev_dq_oe,
  input wire logic echo_clock_true,
  input wire logic echo_clock_comp,
  input wire logic read_valid_flag
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  logic [3:0] echo_idle;
  logic [3:0] next_echo_idle;
  logic echo_last;
  // saturate so a stuck echo never wraps back under the bound
  always_comb begin
    if (echo_clock_true != echo_last) begin
      next_echo_idle = 4'h0;
    end else begin
      next_echo_idle = (echo_idle == 4'hF) ? 4'hF : echo_idle + 4'h1;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      echo_idle <= 4'h0;
      echo_last <= 1'b0;
    end else begin
      echo_idle <= next_echo_idle;
      echo_last <= echo_clock_true;
    end
  end
  a_cmd_stable_rise: assert property (
    $rose(k) |-> $stable(sync_address) && $stable(load_select_n))
    else $error("command pins moved at a true clock rise");
  a_write_two_words: assert property ($rose(host_dq_oe) |-> host_dq_oe[*8])
    else $error("write burst shorter than two words");
  a_write_word_hold: assert property (
    $rose(host_dq_oe) |=> ($stable(host_dq) && $stable(byte_write_strobe_n))[*3])
    else $error("first write word or its strobes changed early");
  a_write_data_delay: assert property (
    $fell(load_select_n) && !read_not_write |-> ##7 !host_dq_oe ##1 host_dq_oe)
    else $error("write data not one K cycle after command");
  a_bus_no_clash: assert property (!(host_dq_oe && dev_dq_oe))
    else $error("both ends drive the data bus");
  a_valid_with_echo: assert property (
    $rose(read_valid_flag) |-> $rose(echo_clock_true) && dev_dq_oe)
    else $error("read valid not aligned with true echo rise");
  a_read_second_word: assert property (
    $rose(read_valid_flag) |=> $stable(dev_dq)[*3] ##1 $rose(echo_clock_comp))
    else $error("second read word not at complement echo rise");
  a_read_valid_span: assert property (
    $rose(read_valid_flag) |-> read_valid_flag[*8] ##1 !read_valid_flag)
    else $error("read valid not one K period long");
  a_echo_pair_aligned: assert property (
    $rose(echo_clock_true) |-> $fell(echo_clock_comp))
    else $error("echo clocks not complementary");
  a_echo_keeps_running: assert property (int'(echo_idle) <= 2 * K_HALF + 4)
    else $error("echo clock stopped");
endmodule
`default_nettype wire

// ==== verif/tb_ddr_burst2_cio_sram_port.sv ====
// Purpose: self-checking bench joining controller and memory ends
// Assumes: 40 MHz SYS_CLK, K period of 200 ns from the controller divider
// Notes: expected words come from a per-address byte-merge model
`default_nettype none
module tb_ddr_burst2_cio_sram_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic LOOP_DISABLE_N = 1'b0;
  logic LATENCY_ONE;
  logic REQ_VALID = 1'b0;
  logic REQ_WRITE = 1'b0;
  logic [7:0] REQ_ADDR = 8'h00;
  logic [71:0] REQ_WDATA = 72'h0;
  logic [7:0] REQ_BE = 8'h00;
  logic REQ_TAKEN;
  logic RD_VALID;
  logic [35:0] RD_DATA;
  logic RD_READY = 1'b0;
  logic [71:0] model [256];
  int errors = 0;
  int n_tests = 0;
  int lat1;
  int lat2;
  int i;
  always #12.5 SYS_CLK = ~SYS_CLK;
  ddb_link_if link ();
  ddb_ctrl_end #(.K_HALF(4)) u_ddb_ctrl_end (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .LINK(link),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
    .REQ_BE(REQ_BE), .REQ_TAKEN(REQ_TAKEN), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .RD_READY(RD_READY));
  ddb_sram_end #(.LOCK_K(2)) u_ddb_sram_end (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .LINK(link),
    .LOOP_DISABLE_N(LOOP_DISABLE_N), .LATENCY_ONE(LATENCY_ONE));
  ddb_link_sva #(.K_HALF(4)) u_ddb_link_sva (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .k(link.k),
    .load_select_n(link.load_select_n), .read_not_write(link.read_not_write),
    .sync_address(link.sync_address), .byte_write_strobe_n(link.byte_write_strobe_n),
    .host_dq(link.host_dq), .host_dq_oe(link.host_dq_oe), .dev_dq(link.dev_dq),
    .dev_dq_oe(link.dev_dq_oe), .echo_clock_true(link.echo_clock_true),
    .echo_clock_comp(link.echo_clock_comp), .read_valid_flag(link.read_valid_flag));
  task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // request held until the controller answers, then dropped at once
  task automatic access(input logic wr, input logic [7:0] a, input logic [71:0] d,
      input logic [7:0] be);
    int n;
    @(negedge SYS_CLK);
    REQ_VALID = 1'b1;
    REQ_WRITE = wr;
    REQ_ADDR = a;
    REQ_WDATA = d;
    REQ_BE = be;
    n = 0;
    while (REQ_TAKEN !== 1'b1 && n < 100) begin
      @(negedge SYS_CLK);
      n++;
    end
    check("request taken", 72'h1, {71'h0, REQ_TAKEN});
    REQ_VALID = 1'b0;
    for (int j = 0; j < 8; j++) begin
      if (wr && be[j]) begin
        model[a][j*9+:9] = d[j*9+:9];
      end
    end
  endtask
  // the receiver stalls until both words sit in the buffer, then drains one per cycle
  task automatic read_chk(input logic [7:0] a, output int lat);
    logic [71:0] got;
    int n;
    access(1'b0, a, 72'h0, 8'h00);
    lat = 0;
    while (RD_VALID !== 1'b1 && lat < 100) begin
      @(negedge SYS_CLK);
      lat++;
    end
    check("read returned", 72'h1, {71'h0, RD_VALID});
    n = 0;
    while (link.read_valid_flag !== 1'b0 && n < 100) begin
      @(negedge SYS_CLK);
      n++;
    end
    check("valid released", 72'h0, {71'h0, link.read_valid_flag});
    repeat (4) @(negedge SYS_CLK);
    // ready stays up across both words so it never toggles within one time step
    for (int w = 0; w < 2; w++) begin
      n = 0;
      while (RD_VALID !== 1'b1 && n < 100) begin
        @(negedge SYS_CLK);
        n++;
      end
      got[w*36+:36] = RD_DATA;
      RD_READY = 1'b1;
      @(negedge SYS_CLK);
    end
    RD_READY = 1'b0;
    check("read burst", model[a], got);
  endtask
  initial begin
    #300000;
    errors++;
    $display("[FAIL] watchdog expected run end seen timeout");
    finish_test();
  end
  initial begin
    repeat (20) @(negedge SYS_CLK);
    RSTN = 1'b1;
    access(1'b1, 8'h05, 72'h0123456789ABCDEF01, 8'hFF);
    access(1'b1, 8'h09, 72'hFEDCBA98765432100F, 8'hFF);
    read_chk(8'h05, lat1);
    check("latency one flag", 72'h1, {71'h0, LATENCY_ONE});
    $display("test bypassed loop done");
    LOOP_DISABLE_N = 1'b1;
    i = 0;
    while (LATENCY_ONE !== 1'b0 && i < 1000) begin
      @(negedge SYS_CLK);
      i++;
    end
    check("latency two flag", 72'h0, {71'h0, LATENCY_ONE});
    read_chk(8'h09, lat2);
    check("latency step", 72'h8, 72'(lat2 - lat1));
    $display("test locked latency done");
    for (int j = 0; j < 4; j++) begin
      access(1'b1, 8'h05, {8{9'(j + 9'h100)}}, 8'(8'h01 << j) | 8'(8'h80 >> j));
      read_chk(8'h05, lat2);
    end
    $display("test lane strobes done");
    access(1'b1, 8'h30, 72'hAAAAAAAAA555555555, 8'hFF);
    read_chk(8'h05, lat2);
    read_chk(8'h30, lat2);
    $display("test committed write done");
    LOOP_DISABLE_N = 1'b0;
    repeat (24) @(negedge SYS_CLK);
    check("loop bypass again", 72'h1, {71'h0, LATENCY_ONE});
    read_chk(8'h30, lat2);
    check("latency back to one", 72'h0, 72'(lat2 - lat1));
    $display("test loop bypass again done");
    finish_test();
  end
endmodule
`default_nettype wire
